// ### logic/cxs_pkg.sv
package cxs_pkg;
  localparam int          WORD_W        = 16;
  localparam int          ADDR_W        = 32;
  // Interface register selects
  typedef enum logic [3:0] {
    REG_RESPONSE, REG_CONTROL, REG_SAVE, REG_RESTORE, REG_OP_WORD,
    REG_COMMAND, REG_RESERVED, REG_CONDITION, REG_OPERAND,
    REG_REG_SELECT, REG_INSTR_ADDR, REG_OPERAND_ADDR
  } cxs_reg_t;
  // Take-exception primitive layout
  localparam int          PRIM_ZERO_BIT = 15;
  localparam int          PRIM_PASS_BIT = 14;
  localparam int          PRIM_CODE_HI  = 13;
  localparam int          PRIM_CODE_LO  = 8;
  localparam logic [5:0]  CODE_PRE      = 6'h1C;
  localparam logic [5:0]  CODE_MID      = 6'h1D;
  localparam logic [5:0]  CODE_POST     = 6'h1E;
  localparam logic [1:0]  KIND_PRE      = 2'h0;
  localparam logic [1:0]  KIND_MID      = 2'h1;
  localparam logic [1:0]  KIND_POST     = 2'h2;
  localparam logic [15:0] PRIM_NULL     = 16'h0802;
  // Control register masks
  localparam logic [15:0] CTRL_EXC_ACK  = 16'h0002;
  localparam logic [15:0] CTRL_ABORT    = 16'h0001;
  // Vectors
  localparam logic [7:0]  VEC_PROTOCOL  = 8'h0D;
  localparam logic [7:0]  VEC_FORMAT    = 8'h0E;
  // Frame sizes in words, format words
  localparam logic [3:0]  FRAME_PRE     = 4'h4;
  localparam logic [3:0]  FRAME_MID     = 4'hA;
  localparam logic [3:0]  FRAME_POST    = 4'h6;
  localparam logic [15:0] FMT_INVALID   = 16'h0100;
  localparam logic [15:0] FMT_VALID_HI  = 16'h0200;
endpackage : cxs_pkg

// ### logic/cxs_if.sv
interface cxs_if;
  logic                   req;
  logic                   wr;
  cxs_pkg::cxs_reg_t      sel;
  logic [15:0]            wdata;
  logic [15:0]            rdata;
  logic                   data_size_ack;
  modport main
  (
    output req, wr, sel, wdata,
    input  rdata, data_size_ack
  );
  modport copro
  (
    input  req, wr, sel, wdata,
    output rdata, data_size_ack
  );
endinterface : cxs_if

// ### logic/cxs_main.sv
// Overview of operation
// - Mid primitive: 0,pass,011101,vector byte
// - Post primitive: 0,pass,011110,vector byte
// - Vector taken from primitive low byte
// - Write acknowledge mask before exception processing
// - Mid primitive builds ten-word frame
// - Mid frame: op address, arrival scan pointer
// - Mid frame address zero if unevaluated
// - Mid return rereads response register, continues
// - Post primitive builds six-word frame
// - Post frame: scan pointer, op address
// - Post: instruction done; resume at scan pointer
// - Coprocessor sends null when no exception is pending
// - Sequenced register access during command wait faults
// - Save/response reads, restore/control writes always allowed
// - Save/restore violations held until next instruction
// - Every access acknowledged; violation reported later
// - Main waits forever for acknowledge
// - Violation reported as mid primitive, vector 13
// - Format errors shown by invalid format word
// - Pre primitive builds four-word frame
// - Invalid format: abort mask, vector 14, four words
module cxs_main
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  cxs_if.main                      bus,
  input  wire logic                start,
  input  wire logic                op_restore,
  input  wire logic [15:0]         restore_word,
  input  wire logic [15:0]         command,
  input  wire logic [31:0]         op_addr,
  input  wire logic [31:0]         scan_pointer,
  input  wire logic [31:0]         eff_addr,
  input  wire logic                eff_addr_valid,
  input  wire logic                resume,
  output logic                     busy,
  output logic                     exc_valid,
  output logic [7:0]               exc_vector,
  output logic [3:0]               exc_frame_words,
  output logic [1:0]               exc_kind,
  output logic                     exc_pass_pc_flag,
  output logic [31:0]              frame_pc,
  output logic [31:0]              frame_scan_pointer,
  output logic [31:0]              frame_eff_addr,
  output logic                     resume_valid,
  output logic [31:0]              resume_addr,
  output logic [15:0]              last_response
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_RESP, ST_ACK, ST_WAIT_RET, ST_RST_WR, ST_ABORT
  } cxs_mst_t;

  typedef struct packed {
    cxs_mst_t    st;
    logic        req;
    logic        wr;
    cxs_pkg::cxs_reg_t sel;
    logic [15:0] wdata;
    logic        exc_valid;
    logic [7:0]  vec;
    logic [3:0]  words;
    logic [1:0]  kind;
    logic        pass;
    logic [31:0] fpc;
    logic [31:0] fscan;
    logic [31:0] fea;
    logic        res_valid;
    logic [31:0] res_addr;
    logic [15:0] resp;
  } cxs_mstate_t;

  cxs_mstate_t s_ff;
  cxs_mstate_t nxt_s;
  logic [1:0]  kind_bits;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.exc_valid = 1'b0;
    nxt_s.res_valid = 1'b0;
    kind_bits = bus.rdata[9:8];
    unique case (s_ff.st)
      ST_IDLE:
      begin
        if (start)
        begin
          nxt_s.req = 1'b1;
          nxt_s.wr = 1'b1;
          nxt_s.sel = op_restore ? cxs_pkg::REG_RESTORE
                                 : cxs_pkg::REG_COMMAND;
          nxt_s.wdata = op_restore ? restore_word : command;
          nxt_s.st = op_restore ? ST_RST_WR : ST_CMD;
        end
      end
      ST_CMD:
      begin
        if (bus.data_size_ack)
        begin
          nxt_s.wr = 1'b0;
          nxt_s.sel = cxs_pkg::REG_RESPONSE;
          nxt_s.st = ST_RESP;
        end
      end
      ST_RST_WR:
      begin
        if (bus.data_size_ack && s_ff.wr)
        begin
          nxt_s.wr = 1'b0;
        end
        else if (bus.data_size_ack)
        begin
          nxt_s.req = 1'b0;
          if (bus.rdata == cxs_pkg::FMT_INVALID)
          begin
            nxt_s.req = 1'b1;
            nxt_s.wr = 1'b1;
            nxt_s.sel = cxs_pkg::REG_CONTROL;
            nxt_s.wdata = cxs_pkg::CTRL_ABORT;
            nxt_s.st = ST_ABORT;
          end
          else
          begin
            nxt_s.st = ST_IDLE;
          end
        end
      end
      ST_ABORT:
      begin
        if (bus.data_size_ack)
        begin
          nxt_s.req = 1'b0;
          nxt_s.exc_valid = 1'b1;
          nxt_s.vec = cxs_pkg::VEC_FORMAT;
          nxt_s.words = cxs_pkg::FRAME_PRE;
          nxt_s.kind = cxs_pkg::KIND_PRE;
          nxt_s.pass = 1'b0;
          nxt_s.fpc = op_addr;
          nxt_s.fscan = scan_pointer;
          nxt_s.fea = eff_addr;
          nxt_s.st = ST_WAIT_RET;
        end
      end
      ST_RESP:
      begin
        if (bus.data_size_ack)
        begin
          nxt_s.resp = bus.rdata;
          if (!bus.rdata[cxs_pkg::PRIM_ZERO_BIT] &&
              bus.rdata[cxs_pkg::PRIM_CODE_HI:cxs_pkg::PRIM_CODE_LO+2]
                == cxs_pkg::CODE_MID[5:2] && kind_bits != 2'h3)
          begin
            nxt_s.vec = bus.rdata[7:0];
            nxt_s.pass = bus.rdata[cxs_pkg::PRIM_PASS_BIT];
            nxt_s.kind = kind_bits;
            nxt_s.words = (kind_bits == cxs_pkg::KIND_MID)
                            ? cxs_pkg::FRAME_MID
                            : (kind_bits == cxs_pkg::KIND_POST)
                              ? cxs_pkg::FRAME_POST
                              : cxs_pkg::FRAME_PRE;
            nxt_s.fpc = op_addr;
            nxt_s.fscan = scan_pointer;
            nxt_s.fea = eff_addr_valid ? eff_addr : 32'h0000_0000;
            nxt_s.wr = 1'b1;
            nxt_s.sel = cxs_pkg::REG_CONTROL;
            nxt_s.wdata = cxs_pkg::CTRL_EXC_ACK;
            nxt_s.st = ST_ACK;
          end
          else
          begin
            nxt_s.req = 1'b0;
            nxt_s.st = ST_IDLE;
          end
        end
      end
      ST_ACK:
      begin
        if (bus.data_size_ack)
        begin
          nxt_s.req = 1'b0;
          nxt_s.exc_valid = 1'b1;
          nxt_s.st = ST_WAIT_RET;
        end
      end
      ST_WAIT_RET:
      begin
        if (resume)
        begin
          if (s_ff.kind == cxs_pkg::KIND_MID)
          begin
            nxt_s.req = 1'b1;
            nxt_s.wr = 1'b0;
            nxt_s.sel = cxs_pkg::REG_RESPONSE;
            nxt_s.st = ST_RESP;
          end
          else
          begin
            nxt_s.res_valid = 1'b1;
            nxt_s.res_addr = (s_ff.kind == cxs_pkg::KIND_POST)
                               ? s_ff.fscan : s_ff.fpc;
            nxt_s.st = ST_IDLE;
          end
        end
      end
      default:
      begin
        nxt_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign bus.req = s_ff.req;
  assign bus.wr = s_ff.wr;
  assign bus.sel = s_ff.sel;
  assign bus.wdata = s_ff.wdata;
  assign busy = (s_ff.st != ST_IDLE);
  assign exc_valid = s_ff.exc_valid;
  assign exc_vector = s_ff.vec;
  assign exc_frame_words = s_ff.words;
  assign exc_kind = s_ff.kind;
  assign exc_pass_pc_flag = s_ff.pass;
  assign frame_pc = s_ff.fpc;
  assign frame_scan_pointer = s_ff.fscan;
  assign frame_eff_addr = s_ff.fea;
  assign resume_valid = s_ff.res_valid;
  assign resume_addr = s_ff.res_addr;
  assign last_response = s_ff.resp;
endmodule : cxs_main

// ### logic/cxs_copro.sv
module cxs_copro
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  cxs_if.copro                     bus,
  input  wire logic                raise_exc,
  input  wire logic [1:0]          raise_kind,
  input  wire logic [7:0]          raise_vector,
  input  wire logic                raise_pass_pc_flag,
  input  wire logic                instr_done,
  output logic                     expect_cmd,
  output logic                     violation_pending,
  output logic                     acked,
  output logic                     aborted
);
  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
    logic        expect_cmd;
    logic        in_ctx;
    logic        viol;
    logic        held_viol;
    logic        exc_pend;
    logic [15:0] exc_word;
    logic        fmt_bad;
    logic        acked;
    logic        aborted;
  } cxs_cstate_t;

  cxs_cstate_t s_ff;
  cxs_cstate_t nxt_s;
  logic        take;
  logic        seq_reg;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.ack = 1'b0;
    nxt_s.acked = 1'b0;
    nxt_s.aborted = 1'b0;
    take = bus.req && !s_ff.ack;
    seq_reg = (bus.sel == cxs_pkg::REG_OP_WORD) ||
              (bus.sel == cxs_pkg::REG_OPERAND) ||
              (bus.sel == cxs_pkg::REG_REG_SELECT) ||
              (bus.sel == cxs_pkg::REG_INSTR_ADDR) ||
              (bus.sel == cxs_pkg::REG_OPERAND_ADDR);
    // Local exception request; set wins over later clears
    if (raise_exc)
    begin
      nxt_s.exc_pend = 1'b1;
      nxt_s.exc_word = {1'b0, raise_pass_pc_flag, cxs_pkg::CODE_PRE[5:2],
                        raise_kind, raise_vector};
    end
    if (take)
    begin
      nxt_s.ack = 1'b1;
      nxt_s.rdata = cxs_pkg::PRIM_NULL;
      if (seq_reg && s_ff.expect_cmd)
      begin
        if (s_ff.in_ctx)
        begin
          nxt_s.held_viol = 1'b1;
        end
        else
        begin
          nxt_s.viol = 1'b1;
        end
      end
      unique case (bus.sel)
        cxs_pkg::REG_COMMAND, cxs_pkg::REG_CONDITION:
        begin
          nxt_s.expect_cmd = 1'b0;
          nxt_s.in_ctx = 1'b0;
          if (s_ff.held_viol)
          begin
            nxt_s.viol = 1'b1;
            nxt_s.held_viol = 1'b0;
          end
        end
        cxs_pkg::REG_RESPONSE:
        begin
          if (s_ff.viol)
          begin
            nxt_s.rdata = {2'b00, cxs_pkg::CODE_MID, cxs_pkg::VEC_PROTOCOL};
          end
          else if (s_ff.exc_pend)
          begin
            nxt_s.rdata = s_ff.exc_word;
          end
        end
        cxs_pkg::REG_CONTROL:
        begin
          if (bus.wr && bus.wdata == cxs_pkg::CTRL_EXC_ACK)
          begin
            nxt_s.viol = 1'b0;
            nxt_s.exc_pend = raise_exc;
            nxt_s.acked = 1'b1;
          end
          else if (bus.wr && bus.wdata == cxs_pkg::CTRL_ABORT)
          begin
            nxt_s.aborted = 1'b1;
            nxt_s.fmt_bad = 1'b0;
            nxt_s.expect_cmd = 1'b1;
            nxt_s.in_ctx = 1'b0;
          end
        end
        cxs_pkg::REG_RESTORE:
        begin
          nxt_s.in_ctx = 1'b1;
          if (bus.wr)
          begin
            nxt_s.fmt_bad = (bus.wdata[15:8] > cxs_pkg::FMT_VALID_HI[15:8]);
          end
          else
          begin
            nxt_s.rdata = s_ff.fmt_bad ? cxs_pkg::FMT_INVALID
                                       : cxs_pkg::FMT_VALID_HI;
          end
        end
        cxs_pkg::REG_SAVE:
        begin
          nxt_s.in_ctx = 1'b1;
          nxt_s.rdata = s_ff.fmt_bad ? cxs_pkg::FMT_INVALID
                                     : cxs_pkg::FMT_VALID_HI;
        end
        default:
        begin
          nxt_s.rdata = cxs_pkg::PRIM_NULL;
        end
      endcase
    end
    // re-arm command wait at completion
    // Placed last so completion beats a command clear
    if (instr_done)
    begin
      nxt_s.expect_cmd = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.expect_cmd <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign bus.data_size_ack = s_ff.ack;
  assign bus.rdata = s_ff.rdata;
  assign expect_cmd = s_ff.expect_cmd;
  assign violation_pending = s_ff.viol | s_ff.held_viol;
  assign acked = s_ff.acked;
  assign aborted = s_ff.aborted;
endmodule : cxs_copro

// ### tb/cxs_assertions.sv
module cxs_chk_assertions
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              req,
  input wire logic              wr,
  input wire cxs_pkg::cxs_reg_t sel,
  input wire logic [15:0]       wdata,
  input wire logic [15:0]       rdata,
  input wire logic              data_size_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic ack;
  logic exc_rd;
  assign ack = data_size_ack;
  // Code 11 in bits 9:8 is no exception, so it is left out
  assign exc_rd = ack && !wr && sel == cxs_pkg::REG_RESPONSE && !rdata[15]
    && rdata[13:10] == 4'h7 && rdata[9:8] != 2'h3;

  ack_follows_req_a: assert property ($rose(req) |=> ack)
    else $error("request not acknowledged after one cycle");
  ack_needs_req_a: assert property (ack |-> $past(req))
    else $error("acknowledge without request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("acknowledge held too long");
  ack_turn_a: assert property (ack ##1 req |=> ack)
    else $error("back-to-back access not acknowledged");
  req_hold_a: assert property (req && !ack |=> req
    && $stable(sel) && $stable(wr) && (!wr || $stable(wdata)))
    else $error("request changed before acknowledge");
  exc_ack_mask_a: assert property (exc_rd |-> ##[1:2] req && wr
    && sel == cxs_pkg::REG_CONTROL && wdata == cxs_pkg::CTRL_EXC_ACK)
    else $error("no acknowledge mask after exception primitive");
  fmt_abort_a: assert property (ack && !wr
    && sel == cxs_pkg::REG_RESTORE && rdata == cxs_pkg::FMT_INVALID
    |-> ##[1:2] req && wr && sel == cxs_pkg::REG_CONTROL
    && wdata == cxs_pkg::CTRL_ABORT)
    else $error("no abort mask after invalid format word");
  cmd_resp_a: assert property (ack && wr
    && sel == cxs_pkg::REG_COMMAND
    |-> ##[1:2] req && !wr && sel == cxs_pkg::REG_RESPONSE)
    else $error("command write not followed by response read");
endmodule : cxs_chk_assertions

// ### tb/coproc_exception_signalling_tb_top.sv
module coproc_exception_signalling_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic        start = 1'h0;
  logic        op_restore = 1'h0;
  logic        eff_addr_valid = 1'h0;
  logic        resume = 1'h0;
  logic        raise_exc = 1'h0;
  logic        raise_pass_pc_flag = 1'h0;
  logic        instr_done = 1'h0;
  logic [1:0]  raise_kind = 2'h0;
  logic [7:0]  raise_vector = 8'h00;
  logic [15:0] restore_word = 16'h0000;
  logic [15:0] command = 16'h0000;
  logic [31:0] op_addr = 32'h0;
  logic [31:0] scan_pointer = 32'h0;
  logic [31:0] eff_addr = 32'h0;
  logic        busy, exc_valid, exc_pass_pc_flag, resume_valid;
  logic        expect_cmd, violation_pending, acked, aborted, vp2;
  logic [7:0]  exc_vector;
  logic [3:0]  exc_frame_words;
  logic [1:0]  exc_kind;
  logic [31:0] frame_pc, frame_scan_pointer, frame_eff_addr, resume_addr;
  logic [15:0] last_response, rd2;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          n_ack = 0;
  int          n_abort = 0;
  int          n_exc = 0;
  cxs_pkg::cxs_reg_t seq_regs [5] = '{cxs_pkg::REG_OP_WORD,
    cxs_pkg::REG_OPERAND, cxs_pkg::REG_REG_SELECT, cxs_pkg::REG_INSTR_ADDR,
    cxs_pkg::REG_OPERAND_ADDR};

  always #12.5 ref_clk = ~ref_clk;

  cxs_if bus_if ();
  // Second pair: the bench plays a careless main to provoke violations
  cxs_if bus2 ();

  cxs_main cxs_main_inst
  (
    .ref_clk, .rst, .bus(bus_if), .start, .op_restore, .restore_word,
    .command, .op_addr, .scan_pointer, .eff_addr, .eff_addr_valid, .resume,
    .busy, .exc_valid, .exc_vector, .exc_frame_words, .exc_kind,
    .exc_pass_pc_flag, .frame_pc, .frame_scan_pointer, .frame_eff_addr,
    .resume_valid, .resume_addr, .last_response
  );
  cxs_copro cxs_copro_inst
  (
    .ref_clk, .rst, .bus(bus_if), .raise_exc, .raise_kind, .raise_vector,
    .raise_pass_pc_flag, .instr_done, .expect_cmd, .violation_pending,
    .acked, .aborted
  );
  cxs_copro cxs_copro_inst2
  (
    .ref_clk, .rst, .bus(bus2), .raise_exc(1'h0), .raise_kind,
    .raise_vector, .raise_pass_pc_flag, .instr_done(1'h0), .expect_cmd(),
    .violation_pending(vp2), .acked(), .aborted()
  );
  cxs_chk_assertions cxs_chk_assertions_inst
  (
    .ref_clk, .rst, .req(bus_if.req), .wr(bus_if.wr), .sel(bus_if.sel),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .data_size_ack(bus_if.data_size_ack)
  );

  always @(posedge ref_clk)
  begin
    n_ack += int'(acked);
    n_abort += int'(aborted);
    n_exc += int'(exc_valid);
  end

  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask : pulse

  // Bounded wait; running out ends the run
  task automatic wait_on(ref logic s, input logic lvl);
    int n;
    n = 0;
    while (s !== lvl && n < 80)
    begin
      tick(1);
      n++;
    end
    if (n >= 80)
    begin
      n_mismatch++;
      $display("MISMATCH %0t wait ran out", $time);
      summarize();
    end
  endtask : wait_on

  function automatic logic [3:0] words(input logic [1:0] k);
    return k == cxs_pkg::KIND_MID ? cxs_pkg::FRAME_MID
      : k == cxs_pkg::KIND_POST ? cxs_pkg::FRAME_POST : cxs_pkg::FRAME_PRE;
  endfunction : words

  function automatic logic proto(input logic [15:0] w);
    return w[15] === 1'h0
      && w[13:0] === {cxs_pkg::CODE_MID, cxs_pkg::VEC_PROTOCOL};
  endfunction : proto

  // Request held until the edge that samples the acknowledge
  task automatic acc2(input logic w, input cxs_pkg::cxs_reg_t s,
                      input logic [15:0] d);
    bus2.req = 1'h1;
    bus2.wr = w;
    bus2.sel = s;
    bus2.wdata = d;
    wait_on(bus2.data_size_ack, 1'h1);
    rd2 = bus2.rdata;
    tick(1);
    bus2.req = 1'h0;
    bus2.wdata = ~d;
    tick(1);
  endtask : acc2

  task automatic run_exc(input logic [1:0] k);
    int a0;
    a0 = n_ack;
    raise_kind = k;
    raise_vector = 8'($urandom);
    raise_pass_pc_flag = 1'($urandom);
    op_addr = $urandom;
    scan_pointer = $urandom;
    eff_addr = $urandom;
    eff_addr_valid = 1'($urandom);
    command = 16'($urandom);
    pulse(raise_exc);
    pulse(start);
    wait_on(exc_valid, 1'h1);
    chk(exc_vector, raise_vector);
    chk(exc_kind, k);
    chk(exc_frame_words, words(k));
    chk(exc_pass_pc_flag, raise_pass_pc_flag);
    chk(frame_pc, op_addr);
    chk(frame_scan_pointer, scan_pointer);
    if (k == cxs_pkg::KIND_MID)
      chk(frame_eff_addr, eff_addr_valid ? eff_addr : 32'h0);
    tick(2);
    chk(n_ack, a0 + 1);
    pulse(resume);
    if (k == cxs_pkg::KIND_MID)
    begin
      wait_on(bus_if.data_size_ack, 1'h1);
      chk(bus_if.sel, cxs_pkg::REG_RESPONSE);
      pulse(instr_done);
    end
    else
    begin
      wait_on(resume_valid, 1'h1);
      chk(resume_addr, k[1] ? scan_pointer : op_addr);
    end
    wait_on(busy, 1'h0);
  endtask : run_exc

  task automatic run_restore(input logic bad);
    int e0;
    int a0;
    e0 = n_exc;
    a0 = n_abort;
    restore_word = {bad ? 8'($urandom_range(255, 3))
      : 8'($urandom_range(2)), 8'($urandom)};
    op_restore = 1'h1;
    pulse(start);
    op_restore = 1'h0;
    // Format error parks the main until the handler returns
    if (bad)
    begin
      wait_on(exc_valid, 1'h1);
      chk({exc_vector, exc_frame_words},
          {cxs_pkg::VEC_FORMAT, cxs_pkg::FRAME_PRE});
      pulse(resume);
      chk(resume_addr, op_addr);
    end
    wait_on(busy, 1'h0);
    tick(2);
    chk(n_exc, e0 + int'(bad));
    chk(n_abort, a0 + int'(bad));
  endtask : run_restore

  initial
  begin
    void'($urandom(95));
    bus2.req = 1'h0;
    bus2.wr = 1'h0;
    bus2.sel = cxs_pkg::REG_RESPONSE;
    bus2.wdata = 16'h0000;
    tick(20);
    rst = 1'h0;
    tick(1);
    chk(expect_cmd, 1'h1);
    command = 16'($urandom);
    pulse(start);
    pulse(instr_done);
    wait_on(busy, 1'h0);
    chk(last_response, cxs_pkg::PRIM_NULL);
    // Each kind once in order, then a random mix
    for (int i = 0; i < 9; i++)
      run_exc(i < 3 ? 2'(i) : 2'($urandom_range(2)));
    for (int i = 0; i < 4; i++)
      run_restore(i[0]);
    acc2(1'h0, cxs_pkg::REG_SAVE, 16'h0000);
    acc2(1'h0, cxs_pkg::REG_RESPONSE, 16'h0000);
    // Abort ends the save, else later faults would be held
    acc2(1'h1, cxs_pkg::REG_CONTROL, cxs_pkg::CTRL_ABORT);
    chk(vp2, 1'h0);
    foreach (seq_regs[i])
    begin
      acc2(1'($urandom), seq_regs[i], 16'($urandom));
      chk(vp2, 1'h1);
      acc2(1'h0, cxs_pkg::REG_RESPONSE, 16'h0000);
      chk(proto(rd2), 1'h1);
      acc2(1'h1, cxs_pkg::REG_CONTROL, cxs_pkg::CTRL_EXC_ACK);
    end
    // Violation inside a restore waits for the next instruction
    acc2(1'h1, cxs_pkg::REG_RESTORE, cxs_pkg::FMT_VALID_HI);
    acc2(1'h1, cxs_pkg::REG_OPERAND, 16'h0000);
    acc2(1'h0, cxs_pkg::REG_RESPONSE, 16'h0000);
    chk(proto(rd2), 1'h0);
    acc2(1'h1, cxs_pkg::REG_COMMAND, 16'($urandom));
    acc2(1'h0, cxs_pkg::REG_RESPONSE, 16'h0000);
    chk(proto(rd2), 1'h1);
    chk(violation_pending, 1'h0);
    summarize();
  end
endmodule : coproc_exception_signalling_tb_top
